// *** core/mqo_pkg.sv ***
// Package for the motion quadrature output block.
// Holds timing figures, limits and the power sequencing state type.
package mqo_pkg;
   // Clock rate and printed times
   localparam int CLK_HZ = 20_000_000;
   localparam int MIN_STATE_NS = 133_000;
   localparam int PD_ENTER_US = 700;
   localparam int PU_BASE_US = 705;
   localparam int PUPD_FRAMES = 75;
   localparam int PU_FRAMES = 40;
   localparam int PUPD_MAX_MS = 50;
   localparam int PU_MAX_MS = 30;
   // Least state time rounds up to whole cycles
   localparam int MIN_STATE_CYC =
      (MIN_STATE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int PD_ENTER_CYC = PD_ENTER_US * (CLK_HZ / 1_000_000);
   localparam int PU_BASE_CYC = PU_BASE_US * (CLK_HZ / 1_000_000);
   localparam int PUPD_MAX_CYC = PUPD_MAX_MS * (CLK_HZ / 1000);
   localparam int PU_MAX_CYC = PU_MAX_MS * (CLK_HZ / 1000);
   // States per frame at each resolution
   localparam int LO_RES_LIMIT = 5;
   localparam int HI_RES_LIMIT = 10;
   localparam logic [1:0] QUAD_INIT = 2'h0;
   localparam int CNT_W = 24;
   localparam int ACC_W = 16;

   // Power sequencing states, one-hot
   typedef enum logic [3:0] {
      MQO_PWR_WAKE = 4'h1,
      MQO_PWR_RUN = 4'h2,
      MQO_PWR_ENTER = 4'h4,
      MQO_PWR_DOWN = 4'h8
   } mqo_pwr_t;
endpackage : mqo_pkg

// *** core/mqo_axis.sv ***
// One quadrature axis: pending count, state pacing, phase outputs.
// Assumes a frame pulse, a run enable and a one-cycle load of delta.
`timescale 1ns/1ps
module mqo_axis
   import mqo_pkg::*;
#(
   parameter int DW = 8
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic frame_tick,
   input wire logic run,
   input wire logic hi_res,
   input wire logic load,
   input wire logic signed [DW-1:0] delta,
   output logic phase_a,
   output logic phase_b,
   output logic [ACC_W-1:0] pending_mag
);
   typedef struct packed {
      logic signed [ACC_W-1:0] acc;
      logic [3:0] steps;
      logic [CNT_W-1:0] hold;
      logic [1:0] quad;
   } mqo_axis_st_t;

   mqo_axis_st_t st_reg, st_next;
   logic [3:0] limit;
   logic signed [ACC_W-1:0] acc_in;

   // Refused at elaboration: a delta must fit the signed accumulator
   if (DW > ACC_W - 1) begin : g_bad_dw
      $error("mqo_axis: DW too wide");
   end

   // Limit per frame follows resolution
   assign limit = hi_res ? 4'(HI_RES_LIMIT) : 4'(LO_RES_LIMIT);
   assign acc_in = ACC_W'(delta);

   // Next state; hold and quad freeze when run is low, acc and steps still update
   always_comb begin
      st_next = st_reg;
      if (frame_tick) begin
         st_next.steps = 4'h0;
      end
      if (load) begin
         // Excess from last frame stays in acc
         st_next.acc = st_reg.acc + acc_in;
      end
      if (run) begin
         if (st_reg.hold != '0) begin
            st_next.hold = st_reg.hold - 1'b1;
         end else if (st_reg.acc != '0 && st_next.steps < limit) begin
            st_next.steps = st_next.steps + 1'b1;
            st_next.hold = CNT_W'(MIN_STATE_CYC - 1);
            // Gray step 00-01-11-10 forward, reverse back
            if (st_reg.acc > 0) begin
               st_next.quad = {st_reg.quad[0], ~st_reg.quad[1]};
               st_next.acc = st_next.acc - 1'b1;
            end else begin
               st_next.quad = {~st_reg.quad[0], st_reg.quad[1]};
               st_next.acc = st_next.acc + 1'b1;
            end
         end
      end else begin
         // Frozen: hold counter stalls so state stretches by PD time
         st_next.hold = st_reg.hold;
         st_next.quad = st_reg.quad;
      end
   end

   // Register; reset enters state 0
   always_ff @(posedge clock) begin
      if (srst) begin
         st_reg <= '{acc: '0, steps: 4'h0, hold: '0, quad: QUAD_INIT};
      end else begin
         st_reg <= st_next;
      end
   end

   assign phase_a = st_reg.quad[1];
   assign phase_b = st_reg.quad[0];
   assign pending_mag = st_reg.acc[ACC_W-1] ? ACC_W'(-st_reg.acc)
                                            : ACC_W'(st_reg.acc);
endmodule : mqo_axis

// *** core/mqo_top.sv ***
// Top of the motion quadrature output block: power sequencing,
// frame timing and two axis engines.
// Assumes motion deltas arrive as a one-cycle strobe once per frame
// and the power-down pin is synchronous to clock.
`timescale 1ns/1ps
// Notes on behaviour
// - Low resolution gives up to five states per frame
// - Each state held at least 133 us
// - High resolution allows up to ten states per frame
// - Excess motion carries into next frame
// - Pending output continues after power-down release
// - Interrupted state stretched by power-down time
// - Machine frozen while power-down held
// - Resume from frozen state, no reset
// - Reset starts machine in state zero
// - Enter power-down about 700 us after rise
// - Valid outputs 705 us plus 75 frames
// - Valid outputs 705 us plus 40 frames
// - X drives horizontal pair, Y vertical pair
module mqo_top
   import mqo_pkg::*;
#(
   parameter int DW = 8,
   parameter int FRAME_CYC = 13333,
   parameter int PD_ENTER_CYCLES = PD_ENTER_CYC,
   parameter int PU_BASE_CYCLES = PU_BASE_CYC
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic power_down_pin,
   input wire logic hi_res,
   input wire logic motion_valid,
   input wire logic signed [DW-1:0] delta_x,
   input wire logic signed [DW-1:0] delta_y,
   output logic horiz_phase_a,
   output logic horiz_phase_b,
   output logic vert_phase_a,
   output logic vert_phase_b,
   output logic outputs_valid,
   output logic powered_down,
   output logic frame_tick
);
   typedef struct packed {
      mqo_pwr_t pwr;
      logic [CNT_W-1:0] frame_cnt;
      logic [CNT_W-1:0] wait_cnt;
      logic [7:0] frames_left;
      logic valid;
   } mqo_top_st_t;

   mqo_top_st_t st_reg, st_next;
   logic run;
   logic tick;
   localparam int N_AXES = 2;
   logic signed [DW-1:0] delta_ax [N_AXES];
   logic [N_AXES-1:0] pha_ax;
   logic [N_AXES-1:0] phb_ax;

   // Frame must pace five states; at high resolution a short frame
   // fits fewer than ten and the rest simply carries over
   if (FRAME_CYC < MIN_STATE_CYC * LO_RES_LIMIT) begin : g_bad_frame
      $error("mqo_top: frame too short for state limit");
   end
   if (FRAME_CYC >= 2 ** CNT_W || PU_BASE_CYCLES >= 2 ** CNT_W
       || PD_ENTER_CYCLES >= 2 ** CNT_W) begin : g_bad_width
      $error("mqo_top: count exceeds counter width");
   end
   if (PD_ENTER_CYCLES < 1) begin : g_bad_enter
      $error("mqo_top: power-down entry needs at least one cycle");
   end

   // Frame divider runs free, one-cycle enable each frame
   assign tick = (st_reg.frame_cnt == CNT_W'(FRAME_CYC - 1));

   // Axes halt as soon as the pin is high; pacing waits with them
   assign run = ~power_down_pin;

   // Power sequencing and validity
   always_comb begin
      st_next = st_reg;
      st_next.frame_cnt = tick ? '0 : st_reg.frame_cnt + 1'b1;
      case (st_reg.pwr)
         MQO_PWR_WAKE: begin
            if (power_down_pin) begin
               st_next.pwr = MQO_PWR_ENTER;
               st_next.wait_cnt = '0;
            end else if (st_reg.wait_cnt < CNT_W'(PU_BASE_CYCLES)) begin
               st_next.wait_cnt = st_reg.wait_cnt + 1'b1;
            end else if (st_reg.frames_left == 8'h0) begin
               st_next.valid = 1'b1;
               st_next.pwr = MQO_PWR_RUN;
            end else if (tick) begin
               st_next.frames_left = st_reg.frames_left - 1'b1;
            end
         end
         MQO_PWR_RUN: begin
            if (power_down_pin) begin
               st_next.pwr = MQO_PWR_ENTER;
               st_next.wait_cnt = '0;
            end
         end
         MQO_PWR_ENTER: begin
            if (!power_down_pin) begin
               // Short pulse: outputs stayed valid, machine resumes
               st_next.pwr = st_reg.valid ? MQO_PWR_RUN : MQO_PWR_WAKE;
            end else if (st_reg.wait_cnt == CNT_W'(PD_ENTER_CYCLES - 1)) begin
               st_next.pwr = MQO_PWR_DOWN;
               st_next.valid = 1'b0;
            end else begin
               st_next.wait_cnt = st_reg.wait_cnt + 1'b1;
            end
         end
         MQO_PWR_DOWN: begin
            if (!power_down_pin) begin
               st_next.pwr = MQO_PWR_WAKE;
               st_next.wait_cnt = '0;
               st_next.frames_left = 8'(PUPD_FRAMES);
            end
         end
         default: st_next.pwr = MQO_PWR_WAKE;
      endcase
   end

   // Register; power-up reset takes the supply-on wake path
   always_ff @(posedge clock) begin
      if (srst) begin
         st_reg <= '{pwr: MQO_PWR_WAKE, frame_cnt: '0, wait_cnt: '0,
                     frames_left: 8'(PU_FRAMES), valid: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign outputs_valid = st_reg.valid;
   assign powered_down = (st_reg.pwr == MQO_PWR_DOWN);
   assign frame_tick = tick;

   // Index 0 is the horizontal pair, index 1 the vertical pair
   assign delta_ax[0] = delta_x;
   assign delta_ax[1] = delta_y;
   assign horiz_phase_a = pha_ax[0];
   assign horiz_phase_b = phb_ax[0];
   assign vert_phase_a = pha_ax[1];
   assign vert_phase_b = phb_ax[1];

   // One engine per axis; counts never cross between axes
   for (genvar i = 0; i < N_AXES; i++) begin : g_axis
      mqo_axis #(.DW(DW)) u_axis (
         .clock(clock),
         .srst(srst),
         .frame_tick(tick),
         .run(run),
         .hi_res(hi_res),
         .load(motion_valid),
         .delta(delta_ax[i]),
         .phase_a(pha_ax[i]),
         .phase_b(phb_ax[i]),
         .pending_mag()
      );
   end
endmodule : mqo_top

// *** verification/mqo_top_sva.sv ***
// Checker for the quadrature output top.
// Bound onto mqo_top; sees only its ports.
`timescale 1ns/1ps
module mqo_top_sva
   import mqo_pkg::*;
#(
   parameter int PD_ENTER_CYCLES = PD_ENTER_CYC
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic power_down_pin,
   input wire logic horiz_phase_a,
   input wire logic horiz_phase_b,
   input wire logic vert_phase_a,
   input wire logic vert_phase_b,
   input wire logic outputs_valid,
   input wire logic powered_down
);
   logic [3:0] ph;
   logic [3:0] prev_reg;
   logic [15:0] hx_reg;
   logic [15:0] hy_reg;
   logic [15:0] pd_reg;
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   assign ph = {horiz_phase_a, horiz_phase_b, vert_phase_a, vert_phase_b};
   // Dwell counters start full, so the first step is free
   always_ff @(posedge clock) begin
      prev_reg <= ph;
      hx_reg <= srst ? 16'hFFFF : (ph[3:2] != prev_reg[3:2]) ? 16'h0
         : hx_reg + {15'h0, hx_reg != 16'hFFFF};
      hy_reg <= srst ? 16'hFFFF : (ph[1:0] != prev_reg[1:0]) ? 16'h0
         : hy_reg + {15'h0, hy_reg != 16'hFFFF};
      pd_reg <= (srst || !power_down_pin) ? 16'h0
         : pd_reg + {15'h0, pd_reg != 16'hFFFF};
   end
   a_reset_clears: assert property (disable iff (1'b0)
      srst |=> ph == 4'h0 && !outputs_valid && !powered_down)
      else $error("reset left phases or flags set");
   a_freeze_hold: assert property (power_down_pin |=> ph == prev_reg)
      else $error("phase moved while power-down held");
   a_gray_step: assert property (!$past(srst) |->
      (ph[3:2] ^ prev_reg[3:2]) != 2'h3 && (ph[1:0] ^ prev_reg[1:0]) != 2'h3)
      else $error("both channels of an axis changed at once");
   a_horiz_dwell: assert property (ph[3:2] != prev_reg[3:2] |->
      hx_reg >= MIN_STATE_CYC - 1) else $error("horizontal state too short");
   a_vert_dwell: assert property (ph[1:0] != prev_reg[1:0] |->
      hy_reg >= MIN_STATE_CYC - 1) else $error("vertical state too short");
   a_enter_late: assert property ($rose(powered_down) |->
      pd_reg >= PD_ENTER_CYCLES) else $error("power-down entered early");
   a_enter_due: assert property (pd_reg == PD_ENTER_CYCLES |->
      ##[0:3] powered_down) else $error("power-down not entered");
   a_down_invalid: assert property (powered_down |-> !outputs_valid)
      else $error("outputs valid while powered down");
endmodule : mqo_top_sva
bind mqo_top mqo_top_sva #(.PD_ENTER_CYCLES(PD_ENTER_CYCLES)) u_sva (
   .clock(clock), .srst(srst), .power_down_pin(power_down_pin),
   .horiz_phase_a(horiz_phase_a), .horiz_phase_b(horiz_phase_b),
   .vert_phase_a(vert_phase_a), .vert_phase_b(vert_phase_b),
   .outputs_valid(outputs_valid), .powered_down(powered_down));

// *** verification/mqo_mouse_model.sv ***
// Mouse controller model: decodes both quadrature pairs into counts.
// Assumes phases change only just after rising clock edges.
`timescale 1ns/1ps
module mqo_mouse_model (
   input wire logic clock,
   input wire logic horiz_phase_a,
   input wire logic horiz_phase_b,
   input wire logic vert_phase_a,
   input wire logic vert_phase_b,
   output logic [31:0] pos_x,
   output logic [31:0] pos_y,
   output logic bad
);
   logic [1:0] qx;
   logic [1:0] qy;
   logic [1:0] lx = 2'h0;
   logic [1:0] ly = 2'h0;
   // Place in the cycle 00, 01, 11, 10
   assign qx = {horiz_phase_a, horiz_phase_a ^ horiz_phase_b};
   assign qy = {vert_phase_a, vert_phase_a ^ vert_phase_b};
   function automatic logic [31:0] mv(input logic [1:0] d);
      return d == 2'h1 ? 32'h1 : d == 2'h3 ? 32'hFFFF_FFFF : 32'h0;
   endfunction : mv
   initial begin
      pos_x = 32'h0;
      pos_y = 32'h0;
      bad = 1'b0;
   end
   // Falling edge: phases settled, never unknown after reset
   always @(negedge clock) begin
      pos_x <= pos_x + mv(qx - lx);
      pos_y <= pos_y + mv(qy - ly);
      bad <= bad | (2'(qx - lx) == 2'h2) | (2'(qy - ly) == 2'h2);
      lx <= qx;
      ly <= qy;
   end
endmodule : mqo_mouse_model

// *** verification/tb_mqo_top.sv ***
// Testbench for the quadrature output top with a mouse model.
// Assumes short power counts and a frame long enough for ten states.
`timescale 1ns/1ps
module tb_mqo_top;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic power_down_pin = 1'b0;
   logic hi_res = 1'b0;
   logic motion_valid = 1'b0;
   logic signed [7:0] delta_x = 8'h0;
   logic signed [7:0] delta_y = 8'h0;
   logic ha, hb, va, vb, outputs_valid, powered_down, frame_tick, bad;
   logic [31:0] pos_x, pos_y;
   int miscompares = 0;
   int checked = 0;
   mqo_top #(.FRAME_CYC(26600), .PD_ENTER_CYCLES(20), .PU_BASE_CYCLES(20))
   u_dut (.clock(clock), .srst(srst), .power_down_pin(power_down_pin),
      .hi_res(hi_res), .motion_valid(motion_valid), .delta_x(delta_x),
      .delta_y(delta_y), .horiz_phase_a(ha), .horiz_phase_b(hb),
      .vert_phase_a(va), .vert_phase_b(vb), .outputs_valid(outputs_valid),
      .powered_down(powered_down), .frame_tick(frame_tick));
   mqo_mouse_model u_mouse (.clock(clock), .horiz_phase_a(ha),
      .horiz_phase_b(hb), .vert_phase_a(va), .vert_phase_b(vb),
      .pos_x(pos_x), .pos_y(pos_y), .bad(bad));
   // 50 ns clock
   initial forever #25 clock = ~clock;
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #5;
   endtask : step
   task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   // Bounded wait into the cycle that carries the frame pulse
   task automatic wait_frame();
      int n;
      n = 0;
      do begin
         step(1);
         n++;
      end while (frame_tick !== 1'b1 && n < 30000);
      chk("frame pulse", 32'(n < 30000), 32'h1);
   endtask : wait_frame
   task automatic t_reset();
      chk("reset phases", {28'h0, ha, hb, va, vb}, 32'h0);
      chk("reset valid", 32'(outputs_valid), 32'h0);
   endtask : t_reset
   // Power-down in mid-state: freeze, resume, stretch; X overflows
   task automatic t_pd_stretch();
      logic [3:0] v;
      int n;
      wait_frame();
      motion_valid = 1'b1;
      delta_x = 8'h07;
      delta_y = 8'h02;
      step(1);
      motion_valid = 1'b0;
      step(1);
      v = {ha, hb, va, vb};
      chk("first step", 32'(v), 32'h5);
      step(1000);
      power_down_pin = 1'b1;
      step(3000);
      chk("powered down", 32'(powered_down), 32'h1);
      chk("frozen phases", 32'({ha, hb, va, vb}), 32'(v));
      power_down_pin = 1'b0;
      step(1);
      chk("not yet valid", 32'(outputs_valid), 32'h0);
      n = 1;
      while ({va, vb} === v[1:0] && n < 3000) begin
         step(1);
         n++;
      end
      chk("stretched state", 32'(n), 32'h67C);
      wait_frame();
      chk("lo-res x", pos_x, 32'h5);
      chk("y count", pos_y, 32'h2);
      chk("sequence", 32'(bad), 32'h0);
   endtask : t_pd_stretch
   // High resolution takes carry plus a negative move in one frame
   task automatic t_hi_res();
      hi_res = 1'b1;
      motion_valid = 1'b1;
      delta_x = 8'hF8;
      delta_y = 8'h0;
      step(1);
      motion_valid = 1'b0;
      wait_frame();
      chk("hi-res x", pos_x, 32'hFFFF_FFFF);
      chk("y idle", pos_y, 32'h2);
   endtask : t_hi_res
   // Reset in mid-run from a phase state away from zero
   task automatic t_mid_reset();
      chk("phases moved", 32'({ha, hb, va, vb} != 4'h0), 32'h1);
      srst = 1'b1;
      step(1);
      chk("mid reset phases", {28'h0, ha, hb, va, vb}, 32'h0);
      chk("mid reset down", 32'(powered_down), 32'h0);
      srst = 1'b0;
      step(2);
      chk("held at zero", {28'h0, ha, hb, va, vb}, 32'h0);
   endtask : t_mid_reset
   initial begin
      step(3);
      srst = 1'b0;
      t_reset();
      t_pd_stretch();
      t_hi_res();
      t_mid_reset();
      give_verdict();
   end
   // Watchdog: about three frames are expected
   initial begin
      repeat (90000) @(posedge clock);
      miscompares++;
      give_verdict();
   end
endmodule : tb_mqo_top
